// ==== src/cocr_consts.vh ====
`ifndef COCR_CONSTS_VH
`define COCR_CONSTS_VH
// ****************************************
// Slave address, command and counts
// ****************************************
`define COCR_SLAVE_ADDR 7'h69
`define COCR_CMD_CODE 8'h00
`define COCR_COUNT_MIN 8'h01
`define COCR_COUNT_MAX 8'h20
// ****************************************
// Byte indices in block-write order
// ****************************************
`define COCR_IDX_CTRL 6'h00
`define COCR_IDX_HOST 6'h01
`define COCR_IDX_SLOT 6'h02
`define COCR_IDX_AUX 6'h03
`define COCR_IDX_MID 6'h04
`define COCR_IDX_DLY 6'h05
`define COCR_IDX_ID 6'h06
// ****************************************
// Writable masks and defaults
// ****************************************
`define COCR_HOST_WMASK 8'h7F
`define COCR_HOST_RST 8'h47
`define COCR_SLOT_WMASK 8'h7F
`define COCR_SLOT_RST 8'h7F
`define COCR_AUX_WMASK 8'hFF
`define COCR_AUX_RST 8'hC7
`define COCR_MID_WMASK 8'h3F
`define COCR_MID_RST 8'h3F
`define COCR_DLY_WMASK 8'h3F
`define COCR_DLY_RST 8'h00
// ****************************************
// Bit positions
// ****************************************
`define COCR_BIT_MULT 7
`define COCR_BIT_HOST3 6
`define COCR_BIT_DISP 7
`define COCR_BIT_SBUS 6
`define COCR_BIT_MID5 3
`define COCR_BIT_MID1 4
`define COCR_BIT_MID0 5
`endif

// ==== src/cocr_regs.v ====
`timescale 1ns/1ns
`include "cocr_consts.vh"
module cocr_regs #(
	parameter [3:0] REVISION_CODE = 4'h5, // Arbitrary value
	parameter [3:0] VENDOR_CODE = 4'hA // Arbitrary value
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Serial pins (open-drain data)
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	// Strap
	input wire current_multiplier_select,
	// Configuration outputs
	output reg [3:0] host_pair_en,
	output reg [6:0] slot_clock_en,
	output reg display_48m_out_en,
	output reg serial_48m_en,
	output reg [2:0] freerun_stop_qual,
	output reg [2:0] freerun_en,
	output reg mid_clock_0_en,
	output reg mid_clock_1_or_aux_en,
	output reg ext_ref_in_or_mid_clock_5_en,
	output reg [2:0] fanout_copy_en,
	output reg [1:0] fanout_copy_delay,
	output reg [1:0] display_edge_rate,
	output reg [1:0] serial_edge_rate,
	output reg [7:0] maker_and_revision
);

// ****************************************
// Pin synchronisers and edges
// ****************************************
reg scl_m;
reg scl_s;
reg scl_d;
reg sda_m;
reg sda_s;
reg sda_d;
reg strap_m;
reg strap_s;
always @(posedge mclk) begin
	if (rst) begin
		scl_m <= 1'b1;
		scl_s <= 1'b1;
		scl_d <= 1'b1;
		sda_m <= 1'b1;
		sda_s <= 1'b1;
		sda_d <= 1'b1;
		strap_m <= 1'b0;
		strap_s <= 1'b0;
	end else begin
		scl_m <= scl_in;
		scl_s <= scl_m;
		scl_d <= scl_s;
		sda_m <= sda_in;
		sda_s <= sda_m;
		sda_d <= sda_s;
		strap_m <= current_multiplier_select;
		strap_s <= strap_m;
	end
end
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

// ****************************************
// Protocol state machine
// ****************************************
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_CMD = 3'h2;
localparam ST_CNT = 3'h3;
localparam ST_DATA = 3'h4;
localparam ST_IGN = 3'h5;

reg [2:0] state;
reg [2:0] ret_state;
reg [7:0] shreg;
reg [3:0] bitcnt;
reg ack_phase;
reg [5:0] idx;
reg [7:0] remain;
reg mult_bit;
reg strap_taken;
reg [7:0] byte1;
reg [7:0] byte2;
reg [7:0] byte3;
reg [7:0] byte4;
reg [7:0] byte5;
wire [7:0] rx = {shreg[6:0], sda_s};

// ****************************************
// Strap capture
// ****************************************
// Sampled once on the first clock after reset release, when strap_s still holds its reset 0; not under reset itself
always @(posedge mclk) begin
	if (rst) begin
		strap_taken <= 1'b0;
		mult_bit <= 1'b0;
	end else if (!strap_taken) begin
		strap_taken <= 1'b1;
		mult_bit <= strap_s;
	end
end

always @(posedge mclk) begin
	if (rst) begin
		state <= ST_IDLE;
		ret_state <= ST_IDLE;
		shreg <= 8'h00;
		bitcnt <= 4'h0;
		ack_phase <= 1'b0;
		idx <= `COCR_IDX_CTRL;
		remain <= 8'h00;
		sda_out <= 1'b0;
		sda_oe <= 1'b0;
		byte1 <= `COCR_HOST_RST;
		byte2 <= `COCR_SLOT_RST;
		byte3 <= `COCR_AUX_RST;
		byte4 <= `COCR_MID_RST;
		byte5 <= `COCR_DLY_RST;
	end else if (start_cond) begin
		state <= ST_ADDR;
		bitcnt <= 4'h0;
		ack_phase <= 1'b0;
		sda_oe <= 1'b0;
	end else if (stop_cond) begin
		state <= ST_IDLE;
		sda_oe <= 1'b0;
	end else if (state != ST_IDLE && state != ST_IGN) begin
		if (ack_phase) begin
			// Release after ack clock so the master regains the line
			if (scl_fall) begin
				sda_oe <= 1'b0;
				ack_phase <= 1'b0;
				state <= ret_state;
			end
		end else if (scl_rise) begin
			shreg <= rx;
			bitcnt <= bitcnt + 4'h1;
		end else if (scl_fall && bitcnt == 4'h8) begin
			bitcnt <= 4'h0;
			ack_phase <= 1'b1;
			sda_oe <= 1'b1;
			case (state)
			ST_ADDR: begin
				// Reads and foreign addresses get no ack
				if (shreg == {`COCR_SLAVE_ADDR, 1'b0}) begin
					ret_state <= ST_CMD;
				end else begin
					sda_oe <= 1'b0;
					ack_phase <= 1'b0;
					state <= ST_IGN;
				end
			end
			ST_CMD: begin
				if (shreg == `COCR_CMD_CODE) begin
					ret_state <= ST_CNT;
				end else begin
					sda_oe <= 1'b0;
					ack_phase <= 1'b0;
					state <= ST_IGN;
				end
			end
			ST_CNT: begin
				if (shreg >= `COCR_COUNT_MIN && shreg <= `COCR_COUNT_MAX) begin
					remain <= shreg;
					idx <= `COCR_IDX_CTRL;
					ret_state <= ST_DATA;
				end else begin
					sda_oe <= 1'b0;
					ack_phase <= 1'b0;
					state <= ST_IGN;
				end
			end
			ST_DATA: begin
				// Each whole byte lands at once; an early stop keeps it
				case (idx)
				`COCR_IDX_HOST: begin
					byte1 <= shreg & `COCR_HOST_WMASK;
				end
				`COCR_IDX_SLOT: begin
					byte2 <= shreg & `COCR_SLOT_WMASK;
				end
				`COCR_IDX_AUX: begin
					byte3 <= shreg & `COCR_AUX_WMASK;
				end
				`COCR_IDX_MID: begin
					byte4 <= shreg & `COCR_MID_WMASK;
				end
				`COCR_IDX_DLY: begin
					byte5 <= shreg & `COCR_DLY_WMASK;
				end
				default: ;
				endcase
				if (idx != `COCR_IDX_ID + 6'h1) begin
					idx <= idx + 6'h1;
				end
				remain <= remain - 8'h01;
				// Bytes beyond the count are not acked
				ret_state <= (remain == 8'h01) ? ST_IGN : ST_DATA;
			end
			default: begin
				sda_oe <= 1'b0;
				ack_phase <= 1'b0;
				state <= ST_IGN;
			end
			endcase
		end
	end
end

// ****************************************
// Decoded configuration outputs
// ****************************************
always @(posedge mclk) begin
	if (rst) begin
		host_pair_en <= 4'hF;
		slot_clock_en <= 7'h7F;
		display_48m_out_en <= 1'b1;
		serial_48m_en <= 1'b1;
		freerun_stop_qual <= 3'h0;
		freerun_en <= 3'h7;
	end else begin
		host_pair_en <= {byte1[`COCR_BIT_HOST3], byte1[2:0]};
		slot_clock_en <= byte2[6:0];
		display_48m_out_en <= byte3[`COCR_BIT_DISP];
		serial_48m_en <= byte3[`COCR_BIT_SBUS];
		freerun_stop_qual <= byte3[5:3];
		freerun_en <= byte3[2:0];
	end
end

// Split by byte group to keep each update path short
always @(posedge mclk) begin
	if (rst) begin
		mid_clock_0_en <= 1'b1;
		mid_clock_1_or_aux_en <= 1'b1;
		ext_ref_in_or_mid_clock_5_en <= 1'b1;
		fanout_copy_en <= 3'h7;
		fanout_copy_delay <= 2'h0;
		display_edge_rate <= 2'h0;
		serial_edge_rate <= 2'h0;
	end else begin
		mid_clock_0_en <= byte4[`COCR_BIT_MID0];
		mid_clock_1_or_aux_en <= byte4[`COCR_BIT_MID1];
		// Controller keeps this set while the pin is an input
		ext_ref_in_or_mid_clock_5_en <= byte4[`COCR_BIT_MID5];
		fanout_copy_en <= byte4[2:0];
		fanout_copy_delay <= byte5[5:4];
		display_edge_rate <= byte5[3:2];
		serial_edge_rate <= byte5[1:0];
	end
end

// ****************************************
// Identity byte
// ****************************************
// Fixed codes; no write path reaches them
always @(posedge mclk) begin
	if (rst) begin
		maker_and_revision <= {REVISION_CODE, VENDOR_CODE};
	end else begin
		maker_and_revision <= {REVISION_CODE, VENDOR_CODE};
	end
end

// ****************************************
// Read-only view
// ****************************************
// No readback path exists, so the strap stays internal
// Read-only multiplier bit joins byte1[6:0] only in this unused view; byte1 never stores it
wire [7:0] host_byte_view = {mult_bit, byte1[6:0]};
wire unused_view = ^host_byte_view;

endmodule // cocr_regs

// ==== tb/cocr_regs_asserts.sv ====
`timescale 1ns/1ns
// ****
// Checker
// ****
module cocr_regs_asserts #(
	parameter [3:0] REVISION_CODE = 4'h5,
	parameter [3:0] VENDOR_CODE = 4'hA
) (
	// Clock, reset, pins
	input wire mclk,
	input wire rst,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe,
	input wire current_multiplier_select,
	// Config
	input wire [3:0] host_pair_en,
	input wire [6:0] slot_clock_en,
	input wire display_48m_out_en,
	input wire serial_48m_en,
	input wire [2:0] freerun_stop_qual,
	input wire [2:0] freerun_en,
	input wire mid_clock_0_en,
	input wire mid_clock_1_or_aux_en,
	input wire ext_ref_in_or_mid_clock_5_en,
	input wire [2:0] fanout_copy_en,
	input wire [1:0] fanout_copy_delay,
	input wire [1:0] display_edge_rate,
	input wire [1:0] serial_edge_rate,
	input wire [7:0] maker_and_revision
);
	default clocking @(posedge mclk); endclocking
	AST_HOST_DEF: assert property (rst |=> host_pair_en == 4'hF)
		else $error("host default");
	AST_SLOT_DEF: assert property (rst |=> slot_clock_en == 7'h7F)
		else $error("slot default");
	AST_AUX_DEF: assert property (rst |=> {display_48m_out_en, serial_48m_en,
		freerun_stop_qual, freerun_en} == 8'hC7) else $error("aux default");
	AST_MID_DEF: assert property (rst |=> {mid_clock_0_en, mid_clock_1_or_aux_en,
		ext_ref_in_or_mid_clock_5_en, fanout_copy_en} == 6'h3F) else $error("mid default");
	AST_FLD_DEF: assert property (rst |=> {fanout_copy_delay,
		display_edge_rate, serial_edge_rate} == 6'h00) else $error("field default");
	AST_ID_FIXED: assert property (disable iff (rst)
		maker_and_revision == {REVISION_CODE, VENDOR_CODE}) else $error("id changed");
	AST_ACK_OFF: assert property (rst |=> !sda_oe)
		else $error("ack in reset");
	AST_PULL_LOW: assert property (disable iff (rst) sda_oe |-> !sda_out)
		else $error("data not low");
	AST_ACK_LEN: assert property (disable iff (rst)
		$rose(sda_oe) |=> sda_oe[*3] ##[1:40] !sda_oe) else $error("ack length");
	cover property (disable iff (rst) $rose(sda_oe));
	cover property (disable iff (rst) $fell(host_pair_en[0]));
	cover property (disable iff (rst) $changed(fanout_copy_delay));
endmodule // cocr_regs_asserts

bind cocr_regs cocr_regs_asserts #(.REVISION_CODE(REVISION_CODE),
	.VENDOR_CODE(VENDOR_CODE)) u_chk (.*);

// ==== tb/cocr_smb_host.sv ====
`timescale 1ns/1ns
// ****
// Bus host model
// ****
module cocr_smb_host (
	// Clock and bus
	input wire mclk,
	input wire sda_line,
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'h1;
		sda_drv = 1'h1;
	end
	// Data moves mid-low so no false start or stop
	task automatic bit_io(input logic b, output logic s);
		scl <= 1'h0;
		repeat (2) @(posedge mclk);
		sda_drv <= b;
		repeat (2) @(posedge mclk);
		scl <= 1'h1;
		repeat (3) @(posedge mclk);
		s = sda_line;
		@(posedge mclk);
	endtask
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'h1, s);
		ack = !s;
	endtask
	task automatic start();
		repeat (4) @(posedge mclk);
		sda_drv <= 1'h0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic stop();
		logic s;
		bit_io(1'h0, s);
		sda_drv <= 1'h1;
		repeat (4) @(posedge mclk);
	endtask
endmodule // cocr_smb_host

// ==== tb/cocr_regs_tb.sv ====
`timescale 1ns/1ns
// ****
// Testbench
// ****
module cocr_regs_tb;
	logic mclk, rst, current_multiplier_select;
	wire scl_in, sda_in, sda_out, sda_oe, sda_drv, display_48m_out_en, serial_48m_en;
	wire mid_clock_0_en, mid_clock_1_or_aux_en, ext_ref_in_or_mid_clock_5_en;
	wire [3:0] host_pair_en;
	wire [6:0] slot_clock_en;
	wire [2:0] freerun_stop_qual, freerun_en, fanout_copy_en;
	wire [1:0] fanout_copy_delay, display_edge_rate, serial_edge_rate;
	wire [7:0] maker_and_revision;
	int fails, comparisons;
	// Pull-up on data, device pulls low
	assign sda_in = sda_drv & ~(sda_oe & ~sda_out);
	wire [38:0] cfg = {host_pair_en, slot_clock_en, display_48m_out_en, serial_48m_en,
		freerun_stop_qual, freerun_en, mid_clock_0_en, mid_clock_1_or_aux_en,
		ext_ref_in_or_mid_clock_5_en, fanout_copy_en, fanout_copy_delay,
		display_edge_rate, serial_edge_rate, maker_and_revision};
	cocr_regs #(.REVISION_CODE(4'h5), .VENDOR_CODE(4'hA)) u_dut (.*);
	cocr_smb_host u_host (.mclk(mclk), .sda_line(sda_in), .scl(scl_in), .sda_drv(sda_drv));
	function automatic [38:0] expv(input [7:0] h, s, a, m, d);
		return {h[6], h[2:0], s[6:0], a, m[5:0], d[5:0], 8'h5A};
	endfunction
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	// Sends bytes, first n must be acked
	task automatic frame(input logic [7:0] q[$], input int n);
		logic a;
		u_host.start();
		foreach (q[i]) begin
			u_host.wr_byte(q[i], a);
			chk(a === (i < n), "ack");
		end
		u_host.stop();
		repeat (4) @(posedge mclk);
	endtask
	task automatic do_reset();
		rst <= 1'h1;
		repeat (8) @(posedge mclk);
		rst <= 1'h0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic finish_test();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		finish_test();
	end
	initial begin
		current_multiplier_select = 1'h1;
		do_reset();
		chk(cfg === expv(8'h47, 8'h7F, 8'hC7, 8'h3F, 8'h00), "defaults");
		frame('{8'hD2, 8'h00, 8'h07, 8'hFF, 8'hB8, 8'h80, 8'h38, 8'hC8, 8'hEA, 8'h00}, 10);
		chk(cfg === expv(8'hB8, 8'h80, 8'h38, 8'hC8, 8'hEA), "full write");
		frame('{8'hD2, 8'h00, 8'h03, 8'h00, 8'h47}, 5);
		frame('{8'hD2, 8'h00, 8'h01, 8'h00, 8'h00}, 4);
		frame('{8'hD2, 8'h00, 8'h20, 8'h00, 8'h47}, 5);
		frame('{8'hD4, 8'h00, 8'h02, 8'h00, 8'h00}, 0);
		frame('{8'hD3, 8'h00, 8'h02, 8'h00, 8'h00}, 0);
		frame('{8'hD2, 8'h01, 8'h02, 8'h00, 8'h00}, 1);
		frame('{8'hD2, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
		frame('{8'hD2, 8'h00, 8'h21, 8'h00, 8'h00}, 2);
		chk(cfg === expv(8'h47, 8'h80, 8'h38, 8'hC8, 8'hEA), "kept");
		do_reset();
		chk(cfg === expv(8'h47, 8'h7F, 8'hC7, 8'h3F, 8'h00), "reset again");
		finish_test();
	end
endmodule // cocr_regs_tb
